//--- amp_bus_assertions.sv
/*
  Concurrent checks on the bus between the two ends of the master port.
  Assumes one clock, rst active high, and instantiation beside amp_if.
*/
`timescale 1ns/1ps
module amp_bus_assertions
  import amp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clock_enable,
  input wire amp_pkg::amp_data_t wdata,
  input wire amp_pkg::amp_strb_t wstrb,
  input wire amp_pkg::amp_id_t wid,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire amp_pkg::amp_id_t bid,
  input wire amp_pkg::amp_resp_t bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire amp_pkg::amp_addr_t araddr,
  input wire amp_pkg::amp_id_t arid,
  input wire amp_pkg::amp_burst_t arburst,
  input wire amp_pkg::amp_len_t arlen,
  input wire amp_pkg::amp_size_t arsize,
  input wire amp_pkg::amp_lock_t arlock,
  input wire logic arvalid,
  input wire logic arready,
  input wire amp_pkg::amp_data_t rdata,
  input wire amp_pkg::amp_resp_t rresp,
  input wire amp_pkg::amp_id_t rid,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Encodings on the address channel
  // ----------------------------------------
  property p_burst; arvalid |-> (arburst == 2'h1 || arburst == 2'h2); endproperty
  a_burst: assert property (p_burst) else $error("burst code out of range");
  property p_size; arvalid |-> arsize <= 3'h3; endproperty
  a_size: assert property (p_size) else $error("size code out of range");
  property p_lock; arvalid |-> arlock != 2'h3; endproperty
  a_lock: assert property (p_lock) else $error("lock code out of range");
  // ----------------------------------------
  // Handshakes and bus rate
  // ----------------------------------------
  property p_arhold;
    arvalid && !(bus_clock_enable && arready) |=> arvalid && $stable({araddr, arid, arburst, arlen, arsize, arlock});
  endproperty
  a_arhold: assert property (p_arhold) else $error("read address dropped early");
  property p_whold;
    wvalid && !(bus_clock_enable && wready) |=> wvalid && $stable({wdata, wstrb, wid, wlast});
  endproperty
  a_whold: assert property (p_whold) else $error("write beat dropped early");
  property p_rhold;
    rvalid && !(bus_clock_enable && rready) |=> rvalid && $stable({rdata, rlast, rresp, rid});
  endproperty
  a_rhold: assert property (p_rhold) else $error("read beat dropped early");
  property p_bhold; bvalid && !(bus_clock_enable && bready) |=> bvalid && $stable({bid, bresp}); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rdy; !$past(rst) |-> bready && rready; endproperty
  a_rdy: assert property (p_rdy) else $error("response ready low");
  property p_ce; $rose(bus_clock_enable) |=> !bus_clock_enable ##1 bus_clock_enable; endproperty
  a_ce: assert property (p_ce) else $error("enable not one in two");
  // Both ends move the valids, wready and arready only on enabled cycles
  property p_rdyce;
    !bus_clock_enable |=> $stable({wready, arready, wvalid, arvalid, rvalid, bvalid});
  endproperty
  a_rdyce: assert property (p_rdyce) else $error("handshake moved off enable");
endmodule

//--- amp_consts.svh
/*
  Constants for the master-port bridge: widths, encodings, timing counts.
  Assumes inclusion by bare name from amp_pkg, amp_master, amp_slave and the testbench.
*/
`ifndef AMP_CONSTS_SVH
`define AMP_CONSTS_SVH
`define AMP_DATA_W 64
`define AMP_STRB_W 8
`define AMP_ID_W 2
`define AMP_ADDR_W 32
`define AMP_RESP_W 2
`define AMP_LEN_W 4
`define AMP_SIZE_W 3
`define AMP_CACHE_W 4
`define AMP_PROT_W 3
`define AMP_USER_W 5
`define AMP_BURST_INCR 2'h1
`define AMP_BURST_WRAP 2'h2
`define AMP_LOCK_NORMAL 2'h0
`define AMP_LOCK_EXCL 2'h1
`define AMP_LOCK_LOCKED 2'h2
`define AMP_SIZE_64 3'h3
`define AMP_ATTR_WBWA 4'hF
`define AMP_USER_SHARED_POS 0
`define AMP_USER_ATTR_LSB 1
`define AMP_FIFO_DEPTH 8
`define AMP_CLKEN_RATIO 2
`endif

//--- amp_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; advance gates both sides so it follows the bus rate.
*/
`timescale 1ns/1ps
module amp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic advance,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  assign push = advance && in_valid && in_ready;
  assign pop = advance && out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop)
      begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- amp_if.sv
/*
  Bus between the processor-side master port and the system slave.
  Assumes both ends share clk and the bus clock enable.
*/
`timescale 1ns/1ps
interface amp_if;
  import amp_pkg::*;
  logic bus_clock_enable;
  amp_data_t wdata;
  amp_strb_t wstrb;
  amp_id_t wid;
  logic wlast;
  logic wvalid;
  logic wready;
  amp_id_t bid;
  amp_resp_t bresp;
  logic bvalid;
  logic bready;
  amp_addr_t araddr;
  amp_id_t arid;
  amp_burst_t arburst;
  amp_len_t arlen;
  amp_size_t arsize;
  amp_lock_t arlock;
  amp_cache_t arcache;
  amp_prot_t arprot;
  amp_user_t aruser;
  logic arvalid;
  logic arready;
  amp_data_t rdata;
  amp_resp_t rresp;
  logic rlast;
  amp_id_t rid;
  logic rvalid;
  logic rready;
  modport master (
    input bus_clock_enable,
    output wdata, wstrb, wid, wlast, wvalid, input wready,
    input bid, bresp, bvalid, output bready,
    output araddr, arid, arburst, arlen, arsize, arlock, arcache, arprot, aruser, arvalid,
    input arready,
    input rdata, rresp, rlast, rid, rvalid, output rready
  );
  modport slave (
    output bus_clock_enable,
    input wdata, wstrb, wid, wlast, wvalid, output wready,
    output bid, bresp, bvalid, input bready,
    input araddr, arid, arburst, arlen, arsize, arlock, arcache, arprot, aruser, arvalid,
    output arready,
    output rdata, rresp, rlast, rid, rvalid, input rready
  );
endinterface

//--- amp_master.sv
/*
  Processor-side end of the first 64-bit master port: write data, write
  response, read address and read data channels. Write beats pass through
  an 8-word FIFO before the bus. Assumes the slave end drives the bus
  clock enable and keeps the valid/ready handshake.
*/
`timescale 1ns/1ps
`include "amp_consts.svh"

module amp_master
  import amp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  amp_if.master bus,
  input wire amp_pkg::amp_data_t user_wdata,
  input wire amp_pkg::amp_strb_t user_wstrb,
  input wire amp_pkg::amp_id_t user_wid,
  input wire logic user_wlast,
  input wire logic user_wvalid,
  output logic user_wready,
  output amp_pkg::amp_id_t user_bid,
  output amp_pkg::amp_resp_t user_bresp,
  output logic user_bvalid,
  input wire amp_pkg::amp_addr_t user_araddr,
  input wire amp_pkg::amp_id_t user_arid,
  input wire logic user_arwrap,
  input wire amp_pkg::amp_len_t user_arlen,
  input wire amp_pkg::amp_size_t user_arsize,
  input wire amp_pkg::amp_lock_t user_arlock,
  input wire amp_pkg::amp_cache_t user_arcache,
  input wire amp_pkg::amp_prot_t user_arprot,
  input wire logic [3:0] user_arattr,
  input wire logic user_arshared,
  input wire logic user_arvalid,
  output logic user_arready,
  output amp_pkg::amp_data_t user_rdata,
  output amp_pkg::amp_resp_t user_rresp,
  output logic user_rlast,
  output amp_pkg::amp_id_t user_rid,
  output logic user_rvalid
);
  import amp_pkg::*;

  localparam int WW = `AMP_DATA_W + `AMP_STRB_W + `AMP_ID_W + 1;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Only the two legal burst codes can ever leave the port
  function automatic amp_burst_t burst_code(input logic wrap);
    burst_code = wrap ? `AMP_BURST_WRAP : `AMP_BURST_INCR;
  endfunction

  // Reserved lock code 11 is folded to a normal access
  function automatic amp_lock_t lock_code(input amp_lock_t l);
    lock_code = (l == 2'h3) ? `AMP_LOCK_NORMAL : l;
  endfunction

  // Beats above 64 bits are not possible on this port
  function automatic amp_size_t size_code(input amp_size_t s);
    size_code = (s > `AMP_SIZE_64) ? `AMP_SIZE_64 : s;
  endfunction

  logic ce;
  assign ce = bus.bus_clock_enable;

  // ------------------------------------------------------------
  // Write data path through the FIFO
  // ------------------------------------------------------------
  logic [WW-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_pop_ready;
  logic fifo_in_ready;

  amp_fifo #(
    .WIDTH(WW),
    .DEPTH(`AMP_FIFO_DEPTH)
  ) u_wfifo (
    .clk(clk),
    .rst(rst),
    .advance(1'b1),
    .in_data({user_wdata, user_wstrb, user_wid, user_wlast}),
    .in_valid(user_wvalid && !user_wready),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop_ready)
  );

  // One-cycle acceptance pulse toward the user keeps this output registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      user_wready <= 1'b0;
    end
    else
    begin
      user_wready <= user_wvalid && !user_wready && fifo_in_ready;
    end
  end

  // Output stage: a beat is loaded only on an enabled cycle, when the bus slot
  // is empty or drained, so the bus side never moves between enable pulses
  assign fifo_pop_ready = ce && (!bus.wvalid || bus.wready);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.wvalid <= 1'b0;
      bus.wdata <= '0;
      bus.wstrb <= '0;
      bus.wid <= '0;
      bus.wlast <= 1'b0;
    end
    else if (fifo_pop_ready)
    begin
      bus.wvalid <= fifo_valid;
      if (fifo_valid)
      begin
        {bus.wdata, bus.wstrb, bus.wid, bus.wlast} <= fifo_out;
      end
    end
  end

  // ------------------------------------------------------------
  // Write response
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.bready <= 1'b0;
      user_bvalid <= 1'b0;
      user_bid <= '0;
      user_bresp <= '0;
    end
    else
    begin
      bus.bready <= 1'b1;
      user_bvalid <= ce && bus.bvalid && bus.bready;
      if (ce && bus.bvalid && bus.bready)
      begin
        user_bid <= bus.bid;
        user_bresp <= bus.bresp;
      end
    end
  end

  // ------------------------------------------------------------
  // Read address
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.arvalid <= 1'b0;
      bus.araddr <= '0;
      bus.arid <= '0;
      bus.arburst <= `AMP_BURST_INCR;
      bus.arlen <= '0;
      bus.arsize <= '0;
      bus.arlock <= `AMP_LOCK_NORMAL;
      bus.arcache <= '0;
      bus.arprot <= '0;
      bus.aruser <= '0;
      user_arready <= 1'b0;
    end
    else
    begin
      user_arready <= 1'b0;
      if (bus.arvalid)
      begin
        if (ce && bus.arready)
        begin
          bus.arvalid <= 1'b0;
        end
      end
      else if (ce && user_arvalid && !user_arready)
      begin
        bus.arvalid <= 1'b1;
        bus.araddr <= user_araddr;
        bus.arid <= user_arid;
        bus.arburst <= burst_code(user_arwrap);
        bus.arlen <= user_arlen;
        bus.arsize <= size_code(user_arsize);
        bus.arlock <= lock_code(user_arlock);
        bus.arcache <= user_arcache;
        bus.arprot <= user_arprot;
        bus.aruser <= {user_arattr, user_arshared};
        user_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.rready <= 1'b0;
      user_rvalid <= 1'b0;
      user_rdata <= '0;
      user_rresp <= '0;
      user_rlast <= 1'b0;
      user_rid <= '0;
    end
    else
    begin
      bus.rready <= 1'b1;
      user_rvalid <= ce && bus.rvalid && bus.rready;
      if (ce && bus.rvalid && bus.rready)
      begin
        user_rdata <= bus.rdata;
        user_rresp <= bus.rresp;
        user_rlast <= bus.rlast;
        user_rid <= bus.rid;
      end
    end
  end
endmodule

//--- amp_pkg.sv
/*
  Types for the master-port bridge.
  Assumes amp_consts.svh is on the include path.
*/
`include "amp_consts.svh"
package amp_pkg;
  typedef logic [`AMP_ID_W-1:0] amp_id_t;
  typedef logic [`AMP_DATA_W-1:0] amp_data_t;
  typedef logic [`AMP_STRB_W-1:0] amp_strb_t;
  typedef logic [`AMP_ADDR_W-1:0] amp_addr_t;
  typedef logic [`AMP_RESP_W-1:0] amp_resp_t;
  typedef logic [`AMP_LEN_W-1:0] amp_len_t;
  typedef logic [`AMP_SIZE_W-1:0] amp_size_t;
  typedef logic [1:0] amp_burst_t;
  typedef logic [1:0] amp_lock_t;
  typedef logic [`AMP_CACHE_W-1:0] amp_cache_t;
  typedef logic [`AMP_PROT_W-1:0] amp_prot_t;
  typedef logic [`AMP_USER_W-1:0] amp_user_t;
endpackage

//--- amp_slave.sv
/*
  System-side end: a simple slave that supplies the bus clock enable,
  accepts write beats, answers each burst with one response and returns
  read bursts of the requested length. Assumes the master keeps valid stable.
*/
`timescale 1ns/1ps
`include "amp_consts.svh"
module amp_slave
  import amp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  amp_if.slave bus,
  output amp_pkg::amp_data_t mem_wdata,
  output amp_pkg::amp_strb_t mem_wstrb,
  output logic mem_wvalid,
  input wire amp_pkg::amp_data_t mem_rdata,
  input wire amp_pkg::amp_resp_t mem_resp
);
  import amp_pkg::*;

  typedef enum {ST_IDLE, ST_DATA} amp_rstate_t;
  amp_rstate_t rstate;
  logic [7:0] div;
  amp_len_t beats_left;
  logic ce;
  assign ce = bus.bus_clock_enable;

  // ------------------------------------------------------------
  // Clock enable divider
  // ------------------------------------------------------------
  // Runs the bus at a fixed integer fraction of clk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div <= '0;
      bus.bus_clock_enable <= 1'b0;
    end
    else
    begin
      div <= (div == 8'(`AMP_CLKEN_RATIO - 1)) ? '0 : div + 1'b1;
      bus.bus_clock_enable <= (div == 8'(`AMP_CLKEN_RATIO - 1));
    end
  end

  // ------------------------------------------------------------
  // Write data and response
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus.wready <= 1'b0;
      bus.bvalid <= 1'b0;
      bus.bid <= '0;
      bus.bresp <= '0;
      mem_wvalid <= 1'b0;
      mem_wdata <= '0;
      mem_wstrb <= '0;
    end
    else
    begin
      mem_wvalid <= 1'b0;
      if (ce)
      begin
        // No new beats while a response waits, so no response is dropped
        bus.wready <= !bus.bvalid;
        if (bus.bvalid && bus.bready)
        begin
          bus.bvalid <= 1'b0;
        end
        if (bus.wvalid && bus.wready)
        begin
          mem_wvalid <= 1'b1;
          mem_wdata <= bus.wdata;
          mem_wstrb <= bus.wstrb;
          if (bus.wlast)
          begin
            bus.bvalid <= 1'b1;
            bus.bid <= bus.wid;
            bus.bresp <= mem_resp;
            bus.wready <= 1'b0;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Read address and data
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rstate <= ST_IDLE;
      bus.arready <= 1'b0;
      bus.rvalid <= 1'b0;
      bus.rdata <= '0;
      bus.rresp <= '0;
      bus.rlast <= 1'b0;
      bus.rid <= '0;
      beats_left <= '0;
    end
    else if (ce)
    begin
      unique case (rstate)
        ST_IDLE:
        begin
          bus.arready <= 1'b1;
          if (bus.arvalid && bus.arready)
          begin
            bus.arready <= 1'b0;
            bus.rvalid <= 1'b1;
            bus.rid <= bus.arid;
            bus.rdata <= mem_rdata;
            bus.rresp <= mem_resp;
            bus.rlast <= (bus.arlen == '0);
            beats_left <= bus.arlen;
            rstate <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (bus.rvalid && bus.rready)
          begin
            if (beats_left == '0)
            begin
              bus.rvalid <= 1'b0;
              bus.rlast <= 1'b0;
              rstate <= ST_IDLE;
            end
            else
            begin
              beats_left <= beats_left - 1'b1;
              bus.rdata <= mem_rdata;
              bus.rlast <= (beats_left == 4'h1);
            end
          end
        end
      endcase
    end
  end
endmodule

//--- tb.sv
/*
  Testbench joining both ends of the master port through amp_if.
  Assumes amp_consts.svh on the include path; inputs change at falling edges.
*/
`timescale 1ns/1ps
`include "amp_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import amp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  amp_data_t user_wdata = '0, mem_rdata = '0, user_rdata, mem_wdata;
  amp_strb_t user_wstrb = '0, mem_wstrb;
  amp_id_t user_wid = '0, user_arid = '0, user_bid, user_rid, last_bid;
  amp_resp_t mem_resp = '0, user_bresp, user_rresp, last_bresp;
  amp_addr_t user_araddr = '0;
  amp_len_t user_arlen = '0;
  amp_size_t user_arsize = '0;
  amp_lock_t user_arlock = '0;
  amp_cache_t user_arcache = '0;
  amp_prot_t user_arprot = '0;
  logic [3:0] user_arattr = '0;
  logic user_wlast = 1'b0, user_wvalid = 1'b0, user_arwrap = 1'b0, user_arshared = 1'b0, user_arvalid = 1'b0;
  logic user_wready, user_bvalid, user_arready, user_rlast, user_rvalid, mem_wvalid;
  logic [56:0] cap_ar;
  amp_data_t wq[$], rq[$];
  amp_resp_t pq[$];
  amp_strb_t sq[$];
  logic lq[$];
  amp_id_t iq[$];
  int bcnt = 0, cyc = 0, fails = 0, num_checks = 0;
  amp_if bus();
  amp_master amp_master_i (.clk, .rst, .bus(bus), .user_wdata, .user_wstrb, .user_wid, .user_wlast, .user_wvalid,
    .user_wready, .user_bid, .user_bresp, .user_bvalid, .user_araddr, .user_arid, .user_arwrap, .user_arlen,
    .user_arsize, .user_arlock, .user_arcache, .user_arprot, .user_arattr, .user_arshared, .user_arvalid,
    .user_arready, .user_rdata, .user_rresp, .user_rlast, .user_rid, .user_rvalid);
  amp_slave amp_slave_i (.clk, .rst, .bus(bus), .mem_wdata, .mem_wstrb, .mem_wvalid, .mem_rdata, .mem_resp);
  amp_bus_assertions amp_bus_assertions_i (.clk, .rst, .bus_clock_enable(bus.bus_clock_enable),
    .wdata(bus.wdata), .wstrb(bus.wstrb), .wid(bus.wid), .wlast(bus.wlast), .wvalid(bus.wvalid),
    .wready(bus.wready), .bid(bus.bid), .bresp(bus.bresp), .bvalid(bus.bvalid), .bready(bus.bready),
    .araddr(bus.araddr), .arid(bus.arid), .arburst(bus.arburst),
    .arlen(bus.arlen), .arsize(bus.arsize), .arlock(bus.arlock), .arvalid(bus.arvalid), .arready(bus.arready),
    .rdata(bus.rdata), .rresp(bus.rresp), .rid(bus.rid), .rlast(bus.rlast), .rvalid(bus.rvalid),
    .rready(bus.rready));
  always #50 clk = ~clk;
  // ----------------------------------------
  // Monitor and closing
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (mem_wvalid === 1'b1)
    begin
      wq.push_back(mem_wdata);
      sq.push_back(mem_wstrb);
    end
    if (user_bvalid === 1'b1)
    begin
      bcnt++;
      last_bid = user_bid;
      last_bresp = user_bresp;
    end
    if (user_rvalid === 1'b1)
    begin
      rq.push_back(user_rdata);
      pq.push_back(user_rresp);
      lq.push_back(user_rlast);
      iq.push_back(user_rid);
    end
    if (bus.arvalid === 1'b1 && bus.arready === 1'b1 && bus.bus_clock_enable === 1'b1)
      cap_ar = {bus.araddr, bus.arid, bus.arburst, bus.arlen, bus.arsize, bus.arlock, bus.arcache, bus.arprot,
        bus.aruser};
    if (cyc == 5000)
    begin
      fails++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  function automatic amp_data_t wd(input int i);
    return 64'hD00D_0000_0000_0000 + 64'(i) * 64'h101;
  endfunction
  task automatic wburst(input int n, input amp_id_t id, input amp_resp_t rs);
    int k;
    mem_resp = rs;
    wq.delete();
    sq.delete();
    bcnt = 0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      user_wdata = wd(i);
      user_wstrb = 8'hFF >> (i % 8);
      user_wid = id;
      user_wlast = (i == n - 1);
      user_wvalid = 1'b1;
      k = 0;
      do begin @(posedge clk); #1; k++; end while (user_wready !== 1'b1 && k < 100);
    end
    @(negedge clk);
    user_wvalid = 1'b0;
    k = 0;
    while (bcnt == 0 && k < 200) begin @(posedge clk); #1; k++; end
    `CHK(wq.size(), n)
    for (int i = 0; i < n && i < wq.size(); i++)
    begin
      `CHK(wq[i], wd(i))
      `CHK(sq[i], amp_strb_t'(8'hFF >> (i % 8)))
    end
    `CHK(bcnt, 1)
    `CHK(last_bid, id)
    `CHK(last_bresp, rs)
  endtask
  task automatic rd(input logic wrap, input amp_len_t len, input amp_size_t sz, input amp_lock_t lk,
    input logic [3:0] attr, input logic sh);
    int k;
    logic [56:0] ex;
    rq.delete();
    pq.delete();
    lq.delete();
    iq.delete();
    @(negedge clk);
    mem_rdata = {32'hBEEF_CAFE, 28'h1000_004, len};
    mem_resp = ~len[1:0];
    user_araddr = {28'h1000_004, len};
    user_arid = len[1:0];
    user_arwrap = wrap;
    user_arlen = len;
    user_arsize = sz;
    user_arlock = lk;
    user_arcache = attr;
    user_arprot = sz;
    user_arattr = attr;
    user_arshared = sh;
    user_arvalid = 1'b1;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (user_arready !== 1'b1 && k < 100);
    @(negedge clk);
    user_arvalid = 1'b0;
    k = 0;
    while (rq.size() < len + 1 && k < 300) begin @(posedge clk); #1; k++; end
    ex = {user_araddr, len[1:0], wrap ? `AMP_BURST_WRAP : `AMP_BURST_INCR, len, (sz > 3'h3) ? `AMP_SIZE_64 : sz,
      (lk == 2'h3) ? `AMP_LOCK_NORMAL : lk, attr, sz, attr, sh};
    `CHK(cap_ar, ex)
    `CHK(rq.size(), len + 1)
    for (int i = 0; i < rq.size(); i++)
    begin
      `CHK(rq[i], mem_rdata)
      `CHK(pq[i], mem_resp)
      `CHK(lq[i], (i == len))
      `CHK(iq[i], len[1:0])
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    wburst(4, 2'h2, 2'h1);
    // A burst longer than the FIFO depth, streamed through at bus rate
    wburst(10, 2'h1, 2'h0);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(1'b0, 4'h0, 3'h0, 2'h0, 4'h0, 1'b1);
    rd(1'b1, 4'h3, 3'h3, 2'h1, 4'hF, 1'b0);
    rd(1'b0, 4'hF, 3'h1, 2'h2, 4'h6, 1'b1);
    rd(1'b1, 4'h1, 3'h7, 2'h3, 4'h3, 1'b0);
    rd(1'b0, 4'h2, 3'h2, 2'h0, 4'h7, 1'b1);
    end_sim();
  end
endmodule
